//--- src/fdic_top.sv
// serial slave port, control words and mode/safety logic of the flash driver
// assumes open-drain sda resolved outside; scl is only sampled, never stretched
module fdic_top
  import fdic_pkg::*;
#(
  parameter logic [6:0] P_SLAVE_ADDR = SLAVE_ADDR_DEF,
  parameter logic [SAFETY_CNT_W-1:0] P_SAFETY_CYCLES = SAFETY_CYCLES_DEF[SAFETY_CNT_W-1:0]
)
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_voltage_mode_pin,
  input wire logic i_torch_enable,
  input wire logic i_overtemp,
  input wire logic i_tx_mask,
  output logic o_power_stage_en,
  output logic o_sinks_en,
  output logic o_voltage_regulation,
  output logic o_flash_ready,
  output logic [9:0] o_torch_outer_ma,
  output logic [9:0] o_torch_center_ma,
  output logic [3:0] o_boost_voltage_code,
  output logic o_hs_mode,
  output logic o_safety_expired
);

  // reset release
  logic rst_meta_r; // first stage of reset release
  logic rst_sync_r; // reset used by the whole design
  logic rstn;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rstn = rst_sync_r;

  // pin synchronisers; bus lines idle high, the rest idle low
  logic [5:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic vpin_f;
  logic torch_en_f;
  logic hot_f;
  logic tx_mask_f;

  fdic_pin_sync #(
    .WIDTH(6),
    .RESET_LEVEL(6'h30)
  ) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rstn(rstn),
    .i_pin({i_scl, i_sda_in, i_voltage_mode_pin, i_torch_enable, i_overtemp, i_tx_mask}),
    .o_level(pins_f)
  );

  assign scl_f = pins_f[5];
  assign sda_f = pins_f[4];
  assign vpin_f = pins_f[3];
  assign torch_en_f = pins_f[2];
  assign hot_f = pins_f[1];
  assign tx_mask_f = pins_f[0];

  // register state, declared early because the serial engine reads it
  fdic_ctrl_one_type ctrl_r; // control word one
  fdic_ctrl_one_type ctrl_nxt;
  logic [4:0] flash_r; // stored flash-current bits of word two
  logic [4:0] flash_nxt;
  logic [3:0] boost_r; // boost voltage code
  logic [3:0] boost_nxt;
  logic [1:0] ot_flags_r; // sticky overtemp flags
  logic [1:0] ot_flags_nxt;
  logic mode_written; // any write touching the shared mode field
  logic safety_expire; // one-cycle timeout pulse

  // serial engine state
  fdic_i2c_state_type st_r;
  fdic_i2c_state_type st_nxt;
  logic [3:0] bitcnt_r; // bits seen or driven in the current byte
  logic [3:0] bitcnt_nxt;
  logic [7:0] shift_r; // receive shifter
  logic [7:0] shift_nxt;
  logic [7:0] tx_r; // transmit shifter
  logic [7:0] tx_nxt;
  logic rw_r; // latched direction bit
  logic rw_nxt;
  logic [2:0] ptr_r; // register pointer
  logic [2:0] ptr_nxt;
  logic sda_low_r; // pulls sda low when set
  logic sda_low_nxt;
  logic nack_r; // master answer after a read byte
  logic nack_nxt;
  logic hs_r; // high-speed mode seen
  logic hs_nxt;
  logic scl_q_r; // previous filtered scl
  logic sda_q_r; // previous filtered sda
  logic wr_stb; // commit pulse for a written byte
  logic rd_stb; // a byte was loaded for reading
  logic [7:0] rd_byte; // read mux output

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // bus conditions from filtered lines
  assign scl_rise = scl_f && !scl_q_r;
  assign scl_fall = !scl_f && scl_q_r;
  assign start_det = scl_f && scl_q_r && sda_q_r && !sda_f;
  assign stop_det = scl_f && scl_q_r && !sda_q_r && sda_f;

  // read mux; bit 7 shows the pin level, not the stored force bit
  always_comb
  begin
    fdic_ctrl_one_type rd_ctrl;
    fdic_flash_word_type rd_flash;
    rd_ctrl = ctrl_r;
    rd_ctrl.voltage_mode_force = vpin_f;
    rd_flash.voltage_mode_force = vpin_f;
    rd_flash.op_select = ctrl_r.op_select;
    rd_flash.flash_fields = flash_r;
    if (ptr_r == REG_CTRL_ONE)
    begin
      rd_byte = rd_ctrl;
    end
    else if (ptr_r == REG_FLASH_CTRL)
    begin
      rd_byte = rd_flash;
    end
    else if (ptr_r == REG_OT_STATUS)
    begin
      rd_byte = {6'h00, ot_flags_r};
    end
    else if (ptr_r == REG_BOOST_CODE)
    begin
      rd_byte = {4'h0, boost_r};
    end
    else
    begin
      rd_byte = READ_ZERO;
    end
  end

  // serial engine next state: sample on scl rise, act on scl fall
  always_comb
  begin
    st_nxt = st_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    rw_nxt = rw_r;
    ptr_nxt = ptr_r;
    sda_low_nxt = sda_low_r;
    nack_nxt = nack_r;
    hs_nxt = hs_r;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    if (stop_det)
    begin
      // release and leave high-speed mode
      st_nxt = ST_IDLE;
      sda_low_nxt = 1'b0;
      hs_nxt = 1'b0;
    end
    else if (start_det)
    begin
      // start or repeated start, hs mode kept across repeats
      st_nxt = ST_ADDR;
      bitcnt_nxt = '0;
      sda_low_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_r == ST_ADDR || st_r == ST_REG || st_r == ST_WDATA)
      begin
        shift_nxt = {shift_r[6:0], sda_f};
        bitcnt_nxt = bitcnt_r + 4'h1;
      end
      else if (st_r == ST_RDATA_ACK)
      begin
        nack_nxt = sda_f;
      end
    end
    else if (scl_fall)
    begin
      case (st_r)
        ST_ADDR:
        begin
          if (bitcnt_r == BITS_PER_BYTE)
          begin
            bitcnt_nxt = '0;
            if (shift_r[7:1] == P_SLAVE_ADDR)
            begin
              st_nxt = ST_ADDR_ACK;
              sda_low_nxt = 1'b1;
              rw_nxt = shift_r[0];
            end
            else
            begin
              // foreign address or master code: stay silent
              if (shift_r[7:3] == HS_CODE_PREFIX)
              begin
                hs_nxt = 1'b1;
              end
              st_nxt = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (rw_r)
          begin
            // first read byte goes out right after the address ack
            st_nxt = ST_RDATA;
            tx_nxt = rd_byte;
            rd_stb = 1'b1;
            sda_low_nxt = !rd_byte[7];
            bitcnt_nxt = FIRST_TX_BIT;
          end
          else
          begin
            st_nxt = ST_REG;
            sda_low_nxt = 1'b0;
          end
        end
        ST_REG:
        begin
          if (bitcnt_r == BITS_PER_BYTE)
          begin
            bitcnt_nxt = '0;
            ptr_nxt = shift_r[2:0];
            st_nxt = ST_REG_ACK;
            sda_low_nxt = 1'b1;
          end
        end
        ST_REG_ACK:
        begin
          st_nxt = ST_WDATA;
          sda_low_nxt = 1'b0;
        end
        ST_WDATA:
        begin
          if (bitcnt_r == BITS_PER_BYTE)
          begin
            bitcnt_nxt = '0;
            st_nxt = ST_WDATA_ACK;
            sda_low_nxt = 1'b1;
          end
        end
        ST_WDATA_ACK:
        begin
          // commit on the falling edge that ends the ack clock
          wr_stb = 1'b1;
          st_nxt = ST_WDATA;
          sda_low_nxt = 1'b0;
        end
        ST_RDATA:
        begin
          if (bitcnt_r == BITS_PER_BYTE)
          begin
            // let go so the master can answer
            bitcnt_nxt = '0;
            st_nxt = ST_RDATA_ACK;
            sda_low_nxt = 1'b0;
          end
          else
          begin
            tx_nxt = {tx_r[6:0], 1'b0};
            sda_low_nxt = !tx_r[6];
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
        end
        ST_RDATA_ACK:
        begin
          if (!nack_r)
          begin
            // master wants more: same register again
            st_nxt = ST_RDATA;
            tx_nxt = rd_byte;
            rd_stb = 1'b1;
            sda_low_nxt = !rd_byte[7];
            bitcnt_nxt = FIRST_TX_BIT;
          end
          else
          begin
            st_nxt = ST_IGNORE;
          end
        end
        default:
        begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= ST_IDLE;
      bitcnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      rw_r <= 1'b0;
      ptr_r <= '0;
      sda_low_r <= 1'b0;
      nack_r <= 1'b1;
      hs_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      rw_r <= rw_nxt;
      ptr_r <= ptr_nxt;
      sda_low_r <= sda_low_nxt;
      nack_r <= nack_nxt;
      hs_r <= hs_nxt;
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // register file next values; a write wins over a same-cycle timeout
  always_comb
  begin
    fdic_flash_word_type wr_flash;
    wr_flash = shift_r;
    ctrl_nxt = ctrl_r;
    flash_nxt = flash_r;
    boost_nxt = boost_r;
    mode_written = 1'b0;
    if (safety_expire)
    begin
      ctrl_nxt.op_select = OP_SHUTDOWN;
    end
    if (wr_stb)
    begin
      if (ptr_r == REG_CTRL_ONE)
      begin
        ctrl_nxt = shift_r;
        mode_written = 1'b1;
      end
      else if (ptr_r == REG_FLASH_CTRL)
      begin
        ctrl_nxt.voltage_mode_force = wr_flash.voltage_mode_force;
        ctrl_nxt.op_select = wr_flash.op_select;
        flash_nxt = wr_flash.flash_fields;
        mode_written = 1'b1;
      end
      else if (ptr_r == REG_BOOST_CODE)
      begin
        boost_nxt = shift_r[3:0];
      end
    end
  end

  // register file
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_ONE_RESET;
      flash_r <= FLASH_FIELDS_RESET;
      boost_r <= BOOST_CODE_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      flash_r <= flash_nxt;
      boost_r <= boost_nxt;
    end
  end

  // mode decode shared by the safety and drive logic
  logic force_eff; // pin or bit forces voltage mode
  logic vm_sel; // voltage mode selected
  logic torch_sel; // led sinks requested
  logic shutdown; // full shutdown
  logic levels_zero; // both torch levels at zero

  assign force_eff = ctrl_r.voltage_mode_force || vpin_f;
  assign vm_sel = force_eff || (ctrl_r.op_select == OP_VOLTAGE);
  assign torch_sel = (ctrl_r.op_select == OP_TORCH) || (ctrl_r.op_select == OP_TORCH_FLASH)
    || ((ctrl_r.op_select == OP_SHUTDOWN) && torch_en_f);
  assign shutdown = (ctrl_r.op_select == OP_SHUTDOWN) && !force_eff && !torch_en_f;
  assign levels_zero = (ctrl_r.torch_level_outer == '0) && (ctrl_r.torch_level_center == '0);

  // safety timer and thermal state
  logic [SAFETY_CNT_W-1:0] safety_cnt_r; // cycles since last mode refresh
  logic [SAFETY_CNT_W-1:0] safety_cnt_nxt;
  logic expired_r; // latched timeout, cleared by a mode refresh
  logic expired_nxt;
  logic suspend_r; // current modes held off after overheating
  logic suspend_nxt;

  // only torch use is timed; the timer restarts on every mode refresh
  always_comb
  begin
    safety_cnt_nxt = safety_cnt_r;
    safety_expire = 1'b0;
    expired_nxt = expired_r;
    ot_flags_nxt = ot_flags_r;
    suspend_nxt = suspend_r;
    if (mode_written || !torch_sel || (ctrl_r.op_select == OP_SHUTDOWN))
    begin
      safety_cnt_nxt = '0;
    end
    else if (safety_cnt_r == P_SAFETY_CYCLES - 1'b1)
    begin
      safety_expire = 1'b1;
      safety_cnt_nxt = '0;
    end
    else
    begin
      safety_cnt_nxt = safety_cnt_r + 1'b1;
    end
    if (mode_written)
    begin
      expired_nxt = 1'b0;
    end
    else if (safety_expire)
    begin
      expired_nxt = 1'b1;
    end
    // clear by read first, so a hot cycle in the same edge still sets
    if (rd_stb && (ptr_r == REG_OT_STATUS))
    begin
      ot_flags_nxt = OT_FLAGS_CLEAR;
    end
    if (hot_f)
    begin
      ot_flags_nxt = OT_FLAGS_SET;
      suspend_nxt = 1'b1;
    end
    else if (mode_written)
    begin
      // a fresh mode write by software lifts the suspension
      suspend_nxt = 1'b0;
    end
  end

  // safety and thermal registers
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      safety_cnt_r <= '0;
      expired_r <= 1'b0;
      ot_flags_r <= OT_FLAGS_CLEAR;
      suspend_r <= 1'b0;
    end
    else
    begin
      safety_cnt_r <= safety_cnt_nxt;
      expired_r <= expired_nxt;
      ot_flags_r <= ot_flags_nxt;
      suspend_r <= suspend_nxt;
    end
  end

  // drive bundle; registered so the analog side sees clean levels
  fdic_drive_type drv_r;
  fdic_drive_type drv_nxt;
  logic halted; // power stage and sinks forced off

  assign halted = hot_f || (suspend_r && !vm_sel);

  always_comb
  begin
    drv_nxt.power_stage_en = !shutdown && !halted;
    drv_nxt.sinks_en = torch_sel && !levels_zero && !halted
      && (ctrl_r.op_select != OP_VOLTAGE);
    drv_nxt.voltage_regulation = !shutdown && (vm_sel || levels_zero);
    drv_nxt.flash_ready = (ctrl_r.op_select == OP_TORCH_FLASH) && !halted;
    drv_nxt.outer_ma = fdic_outer_ma(ctrl_r.torch_level_outer);
    drv_nxt.center_ma = fdic_center_ma(ctrl_r.torch_level_center, tx_mask_f);
    drv_nxt.boost_voltage_code = boost_r;
  end

  // drive register
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drv_r <= '0;
    end
    else
    begin
      drv_r <= drv_nxt;
    end
  end

  // outputs; sda is open drain, only ever pulled low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_low_r;
  assign o_power_stage_en = drv_r.power_stage_en;
  assign o_sinks_en = drv_r.sinks_en;
  assign o_voltage_regulation = drv_r.voltage_regulation;
  assign o_flash_ready = drv_r.flash_ready;
  assign o_torch_outer_ma = drv_r.outer_ma;
  assign o_torch_center_ma = drv_r.center_ma;
  assign o_boost_voltage_code = drv_r.boost_voltage_code;
  assign o_hs_mode = hs_r;
  assign o_safety_expired = expired_r;

endmodule

//--- src/fdic_pkg.sv
// constants, carriers and lookup functions for the flash driver control port
// assumes a single 125 MHz core clock; every pin is synchronised before use
// Function
// - zero mode field shuts down unless forced/torch-enabled
// - overtemp kills power stage, sinks; sticky flags cleared by read
// - after overtemp only voltage mode resumes automatically
// - start is sda falling while scl high
// - seven-bit address plus direction, compared to own address
// - acknowledge only a matching address, ninth clock
// - nine-clock groups: eight data bits plus receiver acknowledge
// - stop is sda rising while scl high; release
// - unimplemented register reads return zero
// - master code 00001xxx recognised, not acknowledged, enters hs
// - hs runs normal protocol; stop returns to f/s
// - write is address, register byte, data byte, each acknowledged
// - data commits on falling edge of its acknowledge clock
// - register byte low three bits select register
// - bit 7 forces voltage mode; reads return pin
// - mode field: shutdown, torch, torch+flash, voltage source
// - mode field must be rewritten within 11.2 s; only torch and torch+flash time out
// - mode field shared between control words one and two
// - outer torch level: 0/50/75/100 mA, reset 01
// - centre torch level eight steps; tx mask allows 350/500
// - both torch levels zero selects voltage regulation
// - voltage regulation uses four-bit boost voltage code
package fdic_pkg;

  // register pointers, low three bits of the register-address byte
  localparam logic [2:0] REG_CTRL_ONE = 3'h1;
  localparam logic [2:0] REG_FLASH_CTRL = 3'h2;
  localparam logic [2:0] REG_OT_STATUS = 3'h3;
  localparam logic [2:0] REG_BOOST_CODE = 3'h4;

  // operating-select codes
  localparam logic [1:0] OP_SHUTDOWN = 2'h0;
  localparam logic [1:0] OP_TORCH = 2'h1;
  localparam logic [1:0] OP_TORCH_FLASH = 2'h2;
  localparam logic [1:0] OP_VOLTAGE = 2'h3;

  // control word one layout, msb first
  typedef struct packed {
    logic voltage_mode_force;
    logic [1:0] op_select;
    logic [1:0] torch_level_outer;
    logic [2:0] torch_level_center;
  } fdic_ctrl_one_type;

  // flash control word layout; the flash-current bits are only stored
  typedef struct packed {
    logic voltage_mode_force;
    logic [1:0] op_select;
    logic [4:0] flash_fields;
  } fdic_flash_word_type;

  // drive bundle towards the analog section
  typedef struct packed {
    logic power_stage_en;
    logic sinks_en;
    logic voltage_regulation;
    logic flash_ready;
    logic [9:0] outer_ma;
    logic [9:0] center_ma;
    logic [3:0] boost_voltage_code;
  } fdic_drive_type;

  localparam fdic_ctrl_one_type CTRL_ONE_RESET = '{1'b0, 2'h0, 2'h1, 3'h1};
  localparam logic [4:0] FLASH_FIELDS_RESET = 5'h03;
  localparam logic [3:0] BOOST_CODE_RESET = 4'h0;
  localparam logic [1:0] OT_FLAGS_SET = 2'h3;
  localparam logic [1:0] OT_FLAGS_CLEAR = 2'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // serial protocol constants
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h33; // arbitrary default
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT = 4'h1;

  // torch safety timeout
  localparam longint unsigned SAFETY_TIMEOUT_MS = 64'd11200;
  localparam longint unsigned CORE_CLK_KHZ = 64'd125000;
  localparam longint unsigned SAFETY_CYCLES_DEF = SAFETY_TIMEOUT_MS * CORE_CLK_KHZ;
  localparam int SAFETY_CNT_W = 31;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
  } fdic_i2c_state_type;

  // outer led torch current in mA
  function automatic logic [9:0] fdic_outer_ma(input logic [1:0] code);
    case (code)
      2'h1: fdic_outer_ma = 10'd50;
      2'h2: fdic_outer_ma = 10'd75;
      2'h3: fdic_outer_ma = 10'd100;
      default: fdic_outer_ma = 10'd0;
    endcase
  endfunction

  // centre led torch current in mA; the top two codes step up under tx mask
  function automatic logic [9:0] fdic_center_ma(input logic [2:0] code, input logic tx_mask);
    case (code)
      3'h1: fdic_center_ma = 10'd50;
      3'h2: fdic_center_ma = 10'd75;
      3'h3: fdic_center_ma = 10'd100;
      3'h4: fdic_center_ma = 10'd125;
      3'h5: fdic_center_ma = 10'd150;
      3'h6: fdic_center_ma = tx_mask ? 10'd350 : 10'd200;
      3'h7: fdic_center_ma = tx_mask ? 10'd500 : 10'd250;
      default: fdic_center_ma = 10'd0;
    endcase
  endfunction

endpackage

//--- src/fdic_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes the reset given here is already synchronous to the clock
module fdic_pin_sync
  import fdic_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_r; // first stage, read only by the second
  logic [WIDTH-1:0] sync_r; // second stage
  logic [WIDTH-1:0] hold_r; // third stage
  logic [WIDTH-1:0] level_r; // filtered level
  logic [WIDTH-1:0] level_nxt;

  // a change is only taken once stages two and three agree,
  // which rejects a single-cycle glitch at the cost of one cycle of delay
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      level_nxt[i] = (sync_r[i] == hold_r[i]) ? hold_r[i] : level_r[i];
    end
  end

  // plain shift chain plus filtered level
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_r <= RESET_LEVEL;
      sync_r <= RESET_LEVEL;
      hold_r <= RESET_LEVEL;
      level_r <= RESET_LEVEL;
    end
    else
    begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      hold_r <= sync_r;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

endmodule

//--- tb/fdic_checker.sv
// pin-level checker for the flash driver control port
// assumes the raw active-low reset and the 125 MHz core clock of the top
module fdic_checker
(
  input logic i_core_clk,
  input logic i_rstn,
  input logic i_scl,
  input logic i_sda_in,
  input logic i_overtemp,
  input logic i_tx_mask,
  input logic o_sda_oe,
  input logic o_power_stage_en,
  input logic o_sinks_en,
  input logic o_flash_ready,
  input logic [9:0] o_torch_outer_ma,
  input logic [9:0] o_torch_center_ma,
  input logic o_hs_mode,
  input logic o_safety_expired
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  // stop, then a quiet bus long enough to cover the pin synchronisers
  sequence s_stop;
    i_scl && $rose(i_sda_in);
  endsequence
  sequence s_quiet;
    (i_scl && i_sda_in) [*6];
  endsequence
  // a hot die must stay unpowered once the sync delay has passed
  property p_hot_off;
    i_overtemp [*6] ##1 i_overtemp [*6] |-> !o_power_stage_en && !o_sinks_en;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("power on while hot");
  property p_center_cap;
    !i_tx_mask [*8] ##1 !i_tx_mask [*4] |-> o_torch_center_ma <= 10'd250;
  endproperty
  a_center_cap: assert property (p_center_cap) else $error("centre level too high");
  property p_outer_set;
    o_torch_outer_ma inside {10'd0, 10'd50, 10'd75, 10'd100};
  endproperty
  a_outer_set: assert property (p_outer_set) else $error("outer level off table");
  // the data line only moves during the low phase of the bus clock
  property p_ack_hold;
    i_scl [*8] |-> $stable(o_sda_oe);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda moved with scl high");
  property p_stop_rel;
    s_stop ##1 s_quiet ##1 s_quiet |-> !o_hs_mode && !o_sda_oe;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("stop not honoured");
  property p_hs_noack;
    $rose(o_hs_mode) |-> !o_sda_oe [*8];
  endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("master code acked");
  property p_expire;
    $rose(o_safety_expired) |-> ##[1:3] !o_flash_ready;
  endproperty
  a_expire: assert property (p_expire) else $error("flash kept after timeout");
  property p_sinks;
    o_sinks_en |-> o_torch_outer_ma != 10'd0 || o_torch_center_ma != 10'd0;
  endproperty
  a_sinks: assert property (p_sinks) else $error("sinks on at zero level");
endmodule
bind fdic_top fdic_checker u_checker (.i_core_clk, .i_rstn, .i_scl, .i_sda_in, .i_overtemp,
  .i_tx_mask, .o_sda_oe, .o_power_stage_en, .o_sinks_en, .o_flash_ready, .o_torch_outer_ma,
  .o_torch_center_ma, .o_hs_mode, .o_safety_expired);

//--- tb/fdic_i2c_host.sv
// bus master model driving the serial port as a host controller does
// assumes the bench resolves open-drain sda with a pull-up
module fdic_i2c_host
(
  input logic i_clk,
  input logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_oe = 1'b0
);
  timeunit 1ns / 1ps;
  // lines change on falling core edges only, in whole cycles
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // one bit: set while scl low, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    o_sda_oe = !b;
    wt(10);
    o_scl = 1'b1;
    wt(12);
    r = i_sda;
    o_scl = 1'b0;
    wt(3);
  endtask
  // s=1 start or repeated start, s=0 stop; sda moves while scl high
  task automatic cond(input logic s);
    o_sda_oe = !s;
    wt(10);
    o_scl = 1'b1;
    wt(12);
    o_sda_oe = s;
    wt(12);
    o_scl = !s;
    wt(3);
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
    output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ai, ao);
  endtask
  // pointer byte, then data out or a repeated start and one byte in
  task automatic access(input logic [6:0] a, input logic [7:0] r, d, input logic rd,
    output logic [7:0] q, output logic [2:0] ak);
    cond(1'b1);
    xfer({a, 1'b0}, 1'b1, q, ak[2]);
    xfer(r, 1'b1, q, ak[1]);
    if (rd)
    begin
      cond(1'b1);
      xfer({a, 1'b1}, 1'b1, q, ak[2]);
    end
    xfer(rd ? 8'hff : d, 1'b1, q, ak[0]);
    cond(1'b0);
  endtask
endmodule

//--- tb/fdic_top_test.sv
// self-checking bench for the flash driver control port
// assumes the host model and the bound checker are compiled first
module fdic_top_test;
  timeunit 1ns / 1ps;
  localparam logic [6:0] ADDR = 7'h33;
  logic clk = 1'b0, rstn = 1'b0, vpin = 1'b0, hot = 1'b0, txm = 1'b0, ten = 1'b0;
  logic [3:0] boost;
  logic scl, host_oe, dut_oe, pwr, sinks, vreg, fready, hs, expired, ak1;
  logic [9:0] outer_ma, center_ma;
  logic [7:0] rb;
  logic [2:0] ak;
  int miscompares = 0, checks = 0, cycles = 0, n = 0;
  // rows: byte written to word one, outer and centre currents it gives
  logic [7:0] wd [8] = '{8'he1, 8'h6a, 8'h73, 8'h7c, 8'h65, 8'h60, 8'h66, 8'h67};
  logic [9:0] om [8] = '{10'd0, 10'd50, 10'd75, 10'd100, 10'd0, 10'd0, 10'd0, 10'd0};
  logic [9:0] cm [8] = '{10'd50, 10'd75, 10'd100, 10'd125, 10'd150, 10'd0, 10'd200, 10'd250};
  // open-drain data line with pull-up
  wire sda = !(host_oe || dut_oe);
  fdic_top #(.P_SAFETY_CYCLES(31'd3000)) u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(), .o_sda_oe(dut_oe), .i_voltage_mode_pin(vpin),
    .i_torch_enable(ten), .i_overtemp(hot), .i_tx_mask(txm), .o_power_stage_en(pwr),
    .o_sinks_en(sinks), .o_voltage_regulation(vreg), .o_flash_ready(fready),
    .o_torch_outer_ma(outer_ma), .o_torch_center_ma(center_ma), .o_boost_voltage_code(boost),
    .o_hs_mode(hs), .o_safety_expired(expired));
  fdic_i2c_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  initial forever #4 clk = !clk;
  // a hung handshake ends the run as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] r, input logic [7:0] e);
    u_host.access(ADDR, r, 8'h00, 1'b1, rb, ak);
    chk(rb, e);
  endtask
  // write word one, then let the drive outputs settle
  task automatic wr(input logic [7:0] d);
    u_host.access(ADDR, 8'h01, d, 1'b0, rb, ak);
    repeat (10) @(negedge clk);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (12) @(negedge clk);
    chk({vreg, center_ma}, {1'b0, 10'd50});
    rdc(8'h01, 8'h09);
    rdc(8'h05, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(wd[i]);
      chk({ak, outer_ma}, {3'b000, om[i]});
      chk(center_ma, cm[i]);
      rdc(8'h01, wd[i] & 8'h7f);
    end
    txm = 1'b1;
    rdc(8'h02, 8'h63);
    chk({vreg, center_ma}, {1'b1, 10'd500});
    u_host.access(7'h34, 8'h01, 8'h29, 1'b0, rb, ak);
    chk(ak[2], 1'b1);
    // master code, then a write chained by repeated start
    u_host.cond(1'b1);
    u_host.xfer(8'h0d, 1'b1, rb, ak1);
    repeat (8) @(negedge clk);
    chk({ak1, hs}, 2'b11);
    wr(8'h29);
    chk({hs, ak, sinks}, 5'b00001);
    hot = 1'b1;
    repeat (12) @(negedge clk);
    chk({pwr, sinks}, 2'b00);
    hot = 1'b0;
    rdc(8'h03, 8'h03);
    rdc(8'h03, 8'h00);
    chk(sinks, 1'b0);
    wr(8'h61);
    hot = 1'b1;
    repeat (12) @(negedge clk);
    hot = 1'b0;
    repeat (12) @(negedge clk);
    chk({vreg, pwr}, 2'b11);
    wr(8'h49);
    chk(fready, 1'b1);
    while (expired !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    chk({n > 2900 && n < 3000, fready}, 2'b10);
    vpin = 1'b1;
    repeat (12) @(negedge clk);
    chk(vreg, 1'b1);
    rdc(8'h01, 8'h89);
    u_host.access(ADDR, 8'h04, 8'h0b, 1'b0, rb, ak);
    repeat (10) @(negedge clk);
    chk(boost, 4'hb);
    rdc(8'h04, 8'h0b);
    vpin = 1'b0;
    repeat (12) @(negedge clk);
    chk({pwr, vreg}, 2'b00);
    ten = 1'b1;
    repeat (12) @(negedge clk);
    chk({pwr, sinks, vreg}, 3'b110);
    end_sim();
  end
endmodule
